//--- verilog/pcf_regs.vh
// Purpose: constants of the command FIR filter and in-position block
// Assumes: 250 MHz clock, AXI4-Lite byte addresses
// Notes: definitions only
`ifndef PCF_REGS_VH
`define PCF_REGS_VH
`define PCF_A_FIR 8'h00
`define PCF_A_RANGE 8'h04
`define PCF_A_RANGE2 8'h08
`define PCF_A_COND 8'h0c
`define PCF_A_HOLD 8'h10
`define PCF_A_EXT2 8'h14
`define PCF_A_CTRL 8'h18
`define PCF_A_STAT 8'h1c
`define PCF_A_DEV 8'h20
`define PCF_A_FILT 8'h24
`define PCF_B_DEVSEL 14
`define PCF_B_REINIT 0
`define PCF_FIR_MAX 14'h2710
`define PCF_RANGE_MAX 19'h40000
`define PCF_HOLD_MAX 15'h7530
`define PCF_FIR_RST 14'h0000
`define PCF_RANGE_RST 19'h0000a
`define PCF_COND_RST 3'h0
`define PCF_HOLD_RST 15'h0000
`define PCF_CLK_MHZ 250
`define PCF_PERIOD_US 100
`define PCF_TICK_CYC (`PCF_PERIOD_US * `PCF_CLK_MHZ)
`define PCF_MS_TICKS (1000 / `PCF_PERIOD_US)
`define PCF_WAIT_ADD_US 250
`define PCF_WAIT_ADD ((`PCF_WAIT_ADD_US + `PCF_PERIOD_US - 1) / `PCF_PERIOD_US)
`define PCF_WAIT_MUL 21
`define PCF_WAIT_DIV 20
`define PCF_WAIT_KNEE 14'h0064
`define PCF_APPLY_DLY 3'h4
`define PCF_RING 10000
`endif

//--- verilog/pcf_top.v
// Purpose: positional command FIR filter with in-position detection
// Assumes: command, motor position and zero-speed come from same-clock logic
// Notes: one control period = PCF_TICK_CYC clocks
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "pcf_regs.vh"
module pcf_top #(
    parameter TICK_CYC = `PCF_TICK_CYC
) (
    // clock and reset
    input wire MCLK_IN,
    input wire RESETN_IN,
    // axi4-lite slave
    input wire [7:0] S_AXI_AWADDR_IN,
    input wire S_AXI_AWVALID_IN,
    output wire S_AXI_AWREADY_OUT,
    input wire [31:0] S_AXI_WDATA_IN,
    input wire [3:0] S_AXI_WSTRB_IN,
    input wire S_AXI_WVALID_IN,
    output wire S_AXI_WREADY_OUT,
    output reg [1:0] S_AXI_BRESP_OUT,
    output reg S_AXI_BVALID_OUT,
    input wire S_AXI_BREADY_IN,
    input wire [7:0] S_AXI_ARADDR_IN,
    input wire S_AXI_ARVALID_IN,
    output wire S_AXI_ARREADY_OUT,
    output reg [31:0] S_AXI_RDATA_OUT,
    output reg [1:0] S_AXI_RRESP_OUT,
    output reg S_AXI_RVALID_OUT,
    input wire S_AXI_RREADY_IN,
    // command and feedback
    input wire [15:0] CMD_DELTA_IN,
    input wire [31:0] MOTOR_POS_IN,
    input wire ZERO_SPEED_IN,
    input wire POS_MODE_IN,
    output wire CTRL_TICK_OUT,
    output reg [31:0] FILT_POS_OUT,
    output reg [32:0] DEVIATION_OUT,
    output reg IN_POSITION_FLAG_OUT,
    output reg IN_POSITION_FLAG_SECOND_OUT
);
    reg [1:0] rst_sync;
    wire rst_n = rst_sync[1];
    always @(posedge MCLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end

    // control period
    reg [19:0] tick_cnt;
    wire tick = (tick_cnt == TICK_CYC[19:0] - 20'h00001);
    assign CTRL_TICK_OUT = tick;
    always @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
            tick_cnt <= 20'h00000;
        else if (tick)
            tick_cnt <= 20'h00000;
        else
            tick_cnt <= tick_cnt + 20'h00001;
    end

    function [31:0] merge;
        input [31:0] old;
        input [31:0] dat;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    merge[i*8 +: 8] = dat[i*8 +: 8];
        end
    endfunction

    // software settings
    reg [13:0] fir_set;
    reg [13:0] fir_act;
    reg [18:0] range1;
    reg [18:0] range2;
    reg [2:0] cond_sel;
    reg [14:0] hold_t;
    reg [31:0] ext2;
    reg pend;
    reg susp;
    reg [2:0] dly_cnt;

    // axi write path: address and data taken in either order
    reg aw_ok;
    reg w_ok;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    assign S_AXI_AWREADY_OUT = !aw_ok;
    assign S_AXI_WREADY_OUT = !w_ok;
    wire wr_go = aw_ok && w_ok && !S_AXI_BVALID_OUT;
    wire [31:0] wr_cur = (aw_addr == `PCF_A_FIR) ? {18'h00000, fir_set} :
                         (aw_addr == `PCF_A_RANGE) ? {13'h0000, range1} :
                         (aw_addr == `PCF_A_RANGE2) ? {13'h0000, range2} :
                         (aw_addr == `PCF_A_COND) ? {29'h00000000, cond_sel} :
                         (aw_addr == `PCF_A_HOLD) ? {17'h00000, hold_t} :
                         (aw_addr == `PCF_A_EXT2) ? ext2 : 32'h00000000;
    wire [31:0] wv = merge(wr_cur, w_data, w_strb);
    wire wr_map = (aw_addr <= `PCF_A_CTRL) && (aw_addr[1:0] == 2'b00);
    wire wr_fir = wr_go && (aw_addr == `PCF_A_FIR);
    wire reinit = wr_go && (aw_addr == `PCF_A_CTRL) && w_strb[0] && w_data[`PCF_B_REINIT];

    always @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_ok <= 1'b0;
            w_ok <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            S_AXI_BVALID_OUT <= 1'b0;
            S_AXI_BRESP_OUT <= 2'b00;
            fir_set <= `PCF_FIR_RST;
            range1 <= `PCF_RANGE_RST;
            range2 <= `PCF_RANGE_RST;
            cond_sel <= `PCF_COND_RST;
            hold_t <= `PCF_HOLD_RST;
            ext2 <= 32'h00000000;
        end
        else
        begin
            if (S_AXI_AWVALID_IN && !aw_ok)
            begin
                aw_ok <= 1'b1;
                aw_addr <= S_AXI_AWADDR_IN;
            end
            if (S_AXI_WVALID_IN && !w_ok)
            begin
                w_ok <= 1'b1;
                w_data <= S_AXI_WDATA_IN;
                w_strb <= S_AXI_WSTRB_IN;
            end
            if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN)
                S_AXI_BVALID_OUT <= 1'b0;
            if (wr_go)
            begin
                aw_ok <= 1'b0;
                w_ok <= 1'b0;
                S_AXI_BVALID_OUT <= 1'b1;
                S_AXI_BRESP_OUT <= wr_map ? 2'b00 : 2'b10;
                // out-of-range FIR, range and hold values saturate so the ring never overflows
                if (aw_addr == `PCF_A_FIR)
                    fir_set <= (wv > {18'h00000, `PCF_FIR_MAX}) ? `PCF_FIR_MAX : wv[13:0];
                if (aw_addr == `PCF_A_RANGE)
                    range1 <= (wv > {13'h0000, `PCF_RANGE_MAX}) ? `PCF_RANGE_MAX : wv[18:0];
                if (aw_addr == `PCF_A_RANGE2)
                    range2 <= (wv > {13'h0000, `PCF_RANGE_MAX}) ? `PCF_RANGE_MAX : wv[18:0];
                if (aw_addr == `PCF_A_COND)
                    cond_sel <= wv[2:0];
                if (aw_addr == `PCF_A_HOLD)
                    hold_t <= (wv > {17'h00000, `PCF_HOLD_MAX}) ? `PCF_HOLD_MAX : wv[14:0];
                if (aw_addr == `PCF_A_EXT2)
                    ext2 <= wv;
            end
        end
    end

    // raw command, ring of past positions, window sum
    reg [31:0] ring [0:`PCF_RING-1];
    reg signed [31:0] raw_pos;
    reg signed [31:0] base_pos;
    reg signed [46:0] psum;
    reg [13:0] wp;
    reg [13:0] fill;
    reg [15:0] idle_cnt;
    wire signed [31:0] raw_n = raw_pos + {{16{CMD_DELTA_IN[15]}}, CMD_DELTA_IN};
    wire [13:0] rd = (wp >= fir_act) ? wp - fir_act : wp + 14'd10000 - fir_act;
    wire [31:0] old = (fill >= fir_act) ? ring[rd] : base_pos;
    wire signed [46:0] prod = raw_n * $signed({1'b0, fir_set});
    // switching wait in control periods, rounded up
    wire [17:0] wait_hi = ({4'h0, fir_set} * 18'd21 + 18'd19) / 18'd20;
    wire [15:0] wait_t = (fir_set < `PCF_WAIT_KNEE) ?
                         {2'b00, fir_set} + 16'd3 : wait_hi[15:0];
    wire [15:0] idle_n = (CMD_DELTA_IN == 16'h0000) ?
                         ((idle_cnt == 16'hffff) ? idle_cnt : idle_cnt + 16'h0001) : 16'h0000;
    wire sw_ok = (idle_n >= wait_t);
    // host must stop pulses for the wait; otherwise the change just waits
    wire apply = reinit || (tick && pend && dly_cnt == 3'h0 && !susp && sw_ok);

    always @(posedge MCLK_IN)
    begin
        if (tick)
            ring[wp] <= raw_n;
    end

    always @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            raw_pos <= 32'sh00000000;
            base_pos <= 32'sh00000000;
            psum <= 47'sh0;
            wp <= 14'h0000;
            fill <= 14'h0000;
            idle_cnt <= 16'h0000;
            fir_act <= `PCF_FIR_RST;
            pend <= 1'b0;
            susp <= 1'b0;
            dly_cnt <= 3'h0;
        end
        else
        begin
            if (tick)
            begin
                raw_pos <= raw_n;
                idle_cnt <= idle_n;
                wp <= (wp == 14'd9999) ? 14'h0000 : wp + 14'h0001;
                if (fill < fir_act)
                    fill <= fill + 14'h0001;
                psum <= psum + {{15{raw_n[31]}}, raw_n} - {{15{old[31]}}, old};
                if (pend && dly_cnt != 3'h0)
                begin
                    dly_cnt <= dly_cnt - 3'h1;
                    if (sw_ok)
                        susp <= 1'b1;
                end
            end
            if (apply)
            begin
                // timed apply follows n idle input periods, so the whole window is raw_n
                fir_act <= fir_set;
                pend <= 1'b0;
                susp <= 1'b0;
                base_pos <= tick ? raw_n : raw_pos;
                psum <= tick ? prod : raw_pos * $signed({1'b0, fir_set});
                fill <= 14'h0000;
            end
            if (wr_fir)
            begin
                pend <= 1'b1;
                susp <= 1'b0;
                dly_cnt <= `PCF_APPLY_DLY;
            end
        end
    end

    // serial divider: window sum over n gives the averaged position
    reg tick_d;
    reg [45:0] dq;
    reg [14:0] drem;
    reg [5:0] dcnt;
    reg dneg;
    reg ddone;
    wire [46:0] pabs = psum[46] ? -psum : psum;
    wire [14:0] rs = {drem[13:0], dq[45]};
    wire ge = (rs >= {1'b0, fir_act});
    always @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_d <= 1'b0;
            dq <= 46'h0;
            drem <= 15'h0000;
            dcnt <= 6'h00;
            dneg <= 1'b0;
            ddone <= 1'b0;
        end
        else
        begin
            tick_d <= tick;
            ddone <= 1'b0;
            if (tick_d)
            begin
                drem <= 15'h0000;
                if (fir_act == 14'h0000)
                begin
                    dq <= {{14{raw_pos[31]}}, raw_pos};
                    dneg <= 1'b0;
                    ddone <= 1'b1;
                end
                else
                begin
                    dq <= pabs[45:0];
                    dneg <= psum[46];
                    dcnt <= 6'd46;
                end
            end
            else if (dcnt != 6'h00)
            begin
                drem <= ge ? rs - {1'b0, fir_act} : rs;
                dq <= {dq[44:0], ge};
                dcnt <= dcnt - 6'h01;
                if (dcnt == 6'h01)
                    ddone <= 1'b1;
            end
        end
    end

    // in-position evaluation, one pass per control period
    reg cmd_on;
    reg ev;
    reg [18:0] tcnt;
    wire [31:0] fnew = dneg ? -dq[31:0] : dq[31:0];
    wire [31:0] ref_pos = ext2[`PCF_B_DEVSEL] ? raw_pos : FILT_POS_OUT;
    wire [32:0] dev = {ref_pos[31], ref_pos} - {MOTOR_POS_IN[31], MOTOR_POS_IN};
    wire [32:0] dabs = dev[32] ? -dev : dev;
    wire in1 = (dabs <= {14'h0000, range1});
    wire in2 = (dabs <= {14'h0000, range2});
    wire [18:0] lim = hold_t * 19'd10;
    wire held = IN_POSITION_FLAG_OUT && (hold_t == 15'h0000 || tcnt < lim);
    reg next_inp;
    always @*
    begin
        case (cond_sel)
            3'h1: next_inp = !cmd_on && in1;
            3'h2: next_inp = !cmd_on && ZERO_SPEED_IN && in1;
            3'h3: next_inp = !cmd_on && (held || in1);
            3'h4: next_inp = !cmd_on && tcnt >= lim && in1;
            default: next_inp = in1;
        endcase
    end
    always @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            FILT_POS_OUT <= 32'h00000000;
            cmd_on <= 1'b0;
            ev <= 1'b0;
            tcnt <= 19'h00000;
            DEVIATION_OUT <= 33'h0;
            IN_POSITION_FLAG_OUT <= 1'b0;
            IN_POSITION_FLAG_SECOND_OUT <= 1'b0;
        end
        else
        begin
            ev <= ddone;
            if (ddone)
            begin
                FILT_POS_OUT <= fnew;
                cmd_on <= (fnew != FILT_POS_OUT);
            end
            if (ev)
            begin
                DEVIATION_OUT <= dev;
                IN_POSITION_FLAG_OUT <= POS_MODE_IN && next_inp;
                IN_POSITION_FLAG_SECOND_OUT <= POS_MODE_IN && in2;
                // hold counts from turn-on, delay counts from command end
                if ((cond_sel == 3'h3) ? !IN_POSITION_FLAG_OUT : cmd_on)
                    tcnt <= 19'h00000;
                else if (tcnt != 19'h7ffff)
                    tcnt <= tcnt + 19'h00001;
            end
        end
    end

    // axi read path
    assign S_AXI_ARREADY_OUT = !S_AXI_RVALID_OUT;
    always @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_RDATA_OUT <= 32'h00000000;
            S_AXI_RRESP_OUT <= 2'b00;
        end
        else if (S_AXI_ARVALID_IN && !S_AXI_RVALID_OUT)
        begin
            S_AXI_RVALID_OUT <= 1'b1;
            S_AXI_RRESP_OUT <= 2'b00;
            case (S_AXI_ARADDR_IN)
                `PCF_A_FIR: S_AXI_RDATA_OUT <= {18'h00000, fir_set};
                `PCF_A_RANGE: S_AXI_RDATA_OUT <= {13'h0000, range1};
                `PCF_A_RANGE2: S_AXI_RDATA_OUT <= {13'h0000, range2};
                `PCF_A_COND: S_AXI_RDATA_OUT <= {29'h00000000, cond_sel};
                `PCF_A_HOLD: S_AXI_RDATA_OUT <= {17'h00000, hold_t};
                `PCF_A_EXT2: S_AXI_RDATA_OUT <= ext2;
                `PCF_A_CTRL: S_AXI_RDATA_OUT <= 32'h00000000;
                `PCF_A_STAT: S_AXI_RDATA_OUT <= {2'b00, fir_act, 12'h000, susp, pend,
                    IN_POSITION_FLAG_SECOND_OUT, IN_POSITION_FLAG_OUT};
                `PCF_A_DEV: S_AXI_RDATA_OUT <= DEVIATION_OUT[31:0];
                `PCF_A_FILT: S_AXI_RDATA_OUT <= FILT_POS_OUT;
                default:
                begin
                    S_AXI_RDATA_OUT <= 32'h00000000;
                    S_AXI_RRESP_OUT <= 2'b10;
                end
            endcase
        end
        else if (S_AXI_RREADY_IN)
            S_AXI_RVALID_OUT <= 1'b0;
    end
endmodule // pcf_top

//--- verif/pcf_top_sva.sv
// Purpose: port checker for pcf_top
// Assumes: bound from the bench top file
// Notes: counters keep long spans out of the properties
`timescale 1ns/1ps
module pcf_top_sva #(
    parameter TICK_CYC = 64
) (
    input wire MCLK_IN,
    input wire RESETN_IN,
    input wire S_AXI_ARVALID_IN,
    input wire S_AXI_ARREADY_OUT,
    input wire S_AXI_BVALID_OUT,
    input wire S_AXI_BREADY_IN,
    input wire [31:0] S_AXI_RDATA_OUT,
    input wire S_AXI_RVALID_OUT,
    input wire S_AXI_RREADY_IN,
    input wire POS_MODE_IN,
    input wire CTRL_TICK_OUT,
    input wire [31:0] FILT_POS_OUT,
    input wire [32:0] DEVIATION_OUT,
    input wire IN_POSITION_FLAG_OUT,
    input wire IN_POSITION_FLAG_SECOND_OUT
);
    reg [15:0] since;
    reg seen;
    reg [15:0] on_cnt;
    reg [15:0] off_cnt;
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!RESETN_IN);
    // saturating counts, so long idle runs never wrap into a false match
    always @(posedge MCLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            since <= 16'hffff;
            seen <= 1'b0;
            on_cnt <= 16'h0000;
            off_cnt <= 16'h0000;
        end
        else
        begin
            since <= CTRL_TICK_OUT ? 16'h0000 : since + {15'h0000, since != 16'hffff};
            seen <= seen | CTRL_TICK_OUT;
            on_cnt <= POS_MODE_IN ? on_cnt + {15'h0000, on_cnt != 16'hffff} : 16'h0000;
            off_cnt <= POS_MODE_IN ? 16'h0000 : off_cnt + {15'h0000, off_cnt != 16'hffff};
        end
    end
    a_bvalid_hold: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT)
        else $error("write response dropped early");
    a_rdata_hold: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN
        |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
        else $error("read data not held");
    a_read_latency: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
        else $error("read answer late");
    a_tick_period: assert property (CTRL_TICK_OUT && seen |-> since == TICK_CYC - 1)
        else $error("control tick spacing wrong");
    a_filt_timing: assert property ($changed(FILT_POS_OUT) |-> since inside {[1:3], [47:49]})
        else $error("filter output moved off its slot");
    a_dev_timing: assert property ($changed(DEVIATION_OUT) |-> since inside {[2:4], [48:50]})
        else $error("deviation moved off its slot");
    a_flag2_zero: assert property (on_cnt > 3 * TICK_CYC && DEVIATION_OUT == 33'h0
        |-> IN_POSITION_FLAG_SECOND_OUT)
        else $error("second flag low at zero deviation");
    a_mode_off: assert property (off_cnt > 3 * TICK_CYC
        |-> !IN_POSITION_FLAG_OUT && !IN_POSITION_FLAG_SECOND_OUT)
        else $error("flag high outside position control");
endmodule // pcf_top_sva

//--- verif/pcf_host_model.sv
// Purpose: host controller sending one delta per control period
// Assumes: the block takes the delta at its tick edge
// Notes: constant-speed bursts only; zero delta means no command
`timescale 1ns/1ps
module pcf_host_model (
    // clock and tick
    input wire clk_in,
    input wire tick_in,
    // burst request
    input wire load_in,
    input wire [7:0] count_in,
    input wire [15:0] speed_in,
    // command
    output reg [15:0] delta_out
);
    reg [7:0] left;
    initial
    begin
        left = 8'h00;
        delta_out = 16'h0000;
    end
    always @(posedge clk_in)
    begin
        if (load_in)
            left <= count_in;
        else if (tick_in)
        begin
            // halted between bursts, so setting changes meet a quiet input
            delta_out <= (left != 8'h00) ? speed_in : 16'h0000;
            left <= (left != 8'h00) ? left - 8'h01 : left;
        end
    end
endmodule // pcf_host_model

//--- verif/pcf_top_test.sv
// Purpose: register and motion tests of pcf_top
// Assumes: control period cut to 64 clocks
// Notes: ticks found by polling the tick output
`timescale 1ns/1ps
`include "pcf_regs.vh"
module pcf_top_test;
    reg clk;
    reg rstn;
    reg [7:0] awaddr;
    reg awvalid;
    reg [31:0] wdata;
    reg wvalid;
    reg bready;
    reg [7:0] araddr;
    reg arvalid;
    reg rready;
    reg [31:0] motor;
    reg zspd;
    reg pmode;
    reg load;
    reg [7:0] cnt;
    reg [7:0] ad;
    reg [31:0] d;
    reg [31:0] prev;
    wire awready;
    wire wready;
    wire [1:0] bresp;
    wire bvalid;
    wire arready;
    wire [31:0] rdata;
    wire [1:0] rresp;
    wire rvalid;
    wire [15:0] delta;
    wire tick;
    wire [31:0] filt;
    wire [32:0] dev;
    wire flag;
    wire flag2;
    integer errors;
    integer comparisons;
    integer k;
    pcf_top #(.TICK_CYC(64)) dut_u (.MCLK_IN(clk), .RESETN_IN(rstn),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
        .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wvalid),
        .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
        .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
        .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
        .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .CMD_DELTA_IN(delta),
        .MOTOR_POS_IN(motor), .ZERO_SPEED_IN(zspd), .POS_MODE_IN(pmode),
        .CTRL_TICK_OUT(tick), .FILT_POS_OUT(filt), .DEVIATION_OUT(dev),
        .IN_POSITION_FLAG_OUT(flag), .IN_POSITION_FLAG_SECOND_OUT(flag2));
    pcf_host_model host_u (.clk_in(clk), .tick_in(tick), .load_in(load), .count_in(cnt),
        .speed_in(16'h0064), .delta_out(delta));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task check(input string what, input [32:0] seen, input [32:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp)
            begin
                errors = errors + 1;
                $display("wrong value %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("comparisons %0d errors %0d", comparisons, errors);
            if (errors == 0 && comparisons > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task limit(input integer n);
        begin
            if (n == 100)
            begin
                $display("wait limit reached");
                errors = errors + 1;
                give_verdict;
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] v, input [1:0] er);
        integer n;
        begin
            @(posedge clk);
            awaddr <= a;
            wdata <= v;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            n = 0;
            while (n < 100)
            begin
                @(posedge clk);
                n = n + 1;
                if (awvalid && awready)
                    awvalid <= 1'b0;
                if (wvalid && wready)
                    wvalid <= 1'b0;
                if (bready && bvalid)
                begin
                    bready <= 1'b0;
                    check("write response", bresp, er);
                    n = 200;
                end
            end
            limit(n);
        end
    endtask
    task rd(input [7:0] a, input [1:0] er, output [31:0] v);
        integer n;
        begin
            @(posedge clk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            n = 0;
            while (n < 100)
            begin
                @(posedge clk);
                n = n + 1;
                if (arvalid && arready)
                    arvalid <= 1'b0;
                if (rready && rvalid)
                begin
                    rready <= 1'b0;
                    v = rdata;
                    check("read response", rresp, er);
                    n = 200;
                end
            end
            limit(n);
        end
    endtask
    task tk(input integer m);
        integer n;
        begin
            repeat (m)
            begin
                n = 0;
                @(posedge clk);
                while (tick !== 1'b1 && n < 100)
                begin
                    @(posedge clk);
                    n = n + 1;
                end
                limit(n);
            end
        end
    endtask
    // burst of cnt deltas starts two ticks after the call
    task burst(input [7:0] c);
        begin
            tk(1);
            load <= 1'b1;
            cnt <= c;
            @(posedge clk);
            load <= 1'b0;
        end
    endtask
    initial
    begin
        errors = 0;
        comparisons = 0;
        rstn = 1'b0;
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h00000000;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b0;
        motor = 32'h00000000;
        zspd = 1'b0;
        pmode = 1'b1;
        load = 1'b0;
        cnt = 8'h00;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        for (ad = 8'h00; ad < 8'h18; ad = ad + 8'h04)
        begin
            rd(ad, 2'b00, d);
            check("reset value", d, (ad == 8'h04 || ad == 8'h08) ? 32'ha : 32'h0);
        end
        rd(8'h28, 2'b10, d);
        check("unmapped read", d, 32'h00000000);
        wr(8'h28, 32'h00000001, 2'b10);
        wr(`PCF_A_RANGE, 32'h00050000, 2'b00);
        rd(`PCF_A_RANGE, 2'b00, d);
        check("range limit", d, 32'h00040000);
        wr(`PCF_A_HOLD, 32'h00009c40, 2'b00);
        rd(`PCF_A_HOLD, 2'b00, d);
        check("hold limit", d, 32'h00007530);
        $display("test registers done");
        // idle time since reset is far shorter than the wait for 8
        wr(`PCF_A_FIR, 32'h00000008, 2'b00);
        tk(9);
        rd(`PCF_A_STAT, 2'b00, d);
        check("wait running", {d[29:16], d[3:2]}, {14'h0000, 2'b01});
        tk(11);
        rd(`PCF_A_STAT, 2'b00, d);
        check("applied after wait", {d[29:16], d[3:2]}, {14'h0008, 2'b00});
        wr(`PCF_A_FIR, 32'h00000004, 2'b00);
        tk(20);
        rd(`PCF_A_STAT, 2'b00, d);
        check("held back", {d[29:16], d[3:2]}, {14'h0008, 2'b11});
        wr(`PCF_A_CTRL, 32'h00000001, 2'b00);
        tk(2);
        rd(`PCF_A_STAT, 2'b00, d);
        check("applied length", {d[29:16], d[3:2]}, {14'h0004, 2'b00});
        $display("test switching done");
        burst(8'h05);
        tk(2);
        prev = filt;
        for (k = 1; k < 10; k = k + 1)
        begin
            tk(1);
            check("speed step", filt - prev, 25 * ((k < 5 ? k : 5) - (k > 4 ? k - 4 : 0)));
            prev = filt;
        end
        check("travel", filt, 32'd500);
        rd(`PCF_A_FILT, 2'b00, d);
        check("filter register", d, 32'd500);
        $display("test ramp done");
        motor <= 32'd505;
        tk(2);
        check("deviation", dev, 33'h1fffffffb);
        check("flag", flag, 1'b1);
        check("flag two", flag2, 1'b1);
        wr(`PCF_A_RANGE2, 32'h00000004, 2'b00);
        tk(2);
        check("flag two range", flag2, 1'b0);
        check("flag alone", flag, 1'b1);
        for (k = 0; k < 2; k = k + 1)
        begin
            motor <= 32'd500 - 32'd262144 - k;
            tk(2);
            check("range edge", flag, k == 0);
        end
        motor <= 32'd500;
        wr(`PCF_A_COND, 32'h00000002, 2'b00);
        for (k = 0; k < 2; k = k + 1)
        begin
            zspd <= k[0];
            tk(2);
            check("zero speed", flag, k[0]);
        end
        $display("test completion done");
        wr(`PCF_A_COND, 32'h00000001, 2'b00);
        wr(`PCF_A_EXT2, 32'h00004000, 2'b00);
        burst(8'h01);
        tk(3);
        check("raw deviation", dev, 33'd100);
        check("moving", flag, 1'b0);
        // raw input already quiet here, only the filter output still moves
        tk(1);
        check("filter still moving", flag, 1'b0);
        tk(4);
        check("settled", flag, 1'b1);
        wr(`PCF_A_HOLD, 32'h00000001, 2'b00);
        wr(`PCF_A_COND, 32'h00000004, 2'b00);
        burst(8'h01);
        tk(10);
        check("delay running", flag, 1'b0);
        tk(8);
        check("delay over", flag, 1'b1);
        pmode <= 1'b0;
        tk(4);
        check("mode off", {flag, flag2}, 2'b00);
        $display("test source done");
        give_verdict;
    end
endmodule // pcf_top_test
bind pcf_top pcf_top_sva #(.TICK_CYC(TICK_CYC)) chk_u (.MCLK_IN(MCLK_IN),
    .RESETN_IN(RESETN_IN), .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN),
    .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT), .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT),
    .S_AXI_BREADY_IN(S_AXI_BREADY_IN), .S_AXI_RDATA_OUT(S_AXI_RDATA_OUT),
    .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .S_AXI_RREADY_IN(S_AXI_RREADY_IN),
    .POS_MODE_IN(POS_MODE_IN), .CTRL_TICK_OUT(CTRL_TICK_OUT), .FILT_POS_OUT(FILT_POS_OUT),
    .DEVIATION_OUT(DEVIATION_OUT), .IN_POSITION_FLAG_OUT(IN_POSITION_FLAG_OUT),
    .IN_POSITION_FLAG_SECOND_OUT(IN_POSITION_FLAG_SECOND_OUT));
